// ===== pkg/acr_pkg.sv
// package for the channel and reference select block of a 10-bit converter
// assumes a 32-bit apb slave, one word per register, index times four
package acr_pkg;
  // ----------------------------------------------------------------------
  // register indices and byte addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0]  IDX_RESULT_LOW   = 8'h78;
  localparam logic [7:0]  IDX_RESULT_HIGH  = 8'h79;
  localparam logic [7:0]  IDX_CHAN_REF_SEL = 8'h7c;
  localparam logic [7:0]  IDX_CONV_STATUS  = 8'h7d;
  localparam logic [11:0] ADDR_RESULT_LOW   = {2'h0, IDX_RESULT_LOW, 2'h0};
  localparam logic [11:0] ADDR_RESULT_HIGH  = {2'h0, IDX_RESULT_HIGH, 2'h0};
  localparam logic [11:0] ADDR_CHAN_REF_SEL = {2'h0, IDX_CHAN_REF_SEL, 2'h0};
  localparam logic [11:0] ADDR_CONV_STATUS  = {2'h0, IDX_CONV_STATUS, 2'h0};

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int          POS_REF_SELECT   = 6;
  localparam int          POS_LEFT_ADJUST  = 5;
  localparam int          POS_FLAG         = 0;
  localparam int          POS_BUSY         = 1;
  localparam logic [7:0]  SEL_WRITE_MASK   = 8'h6f;
  localparam logic [7:0]  SEL_RESET        = 8'h00;
  localparam logic [9:0]  RESULT_RESET     = 10'h000;
  localparam logic [9:0]  CODE_GROUND      = 10'h000;
  localparam logic [9:0]  CODE_FULL_SCALE  = 10'h3ff;
  localparam int          CODE_STEPS       = 1024;

  // ----------------------------------------------------------------------
  // channel codes
  // ----------------------------------------------------------------------
  localparam logic [3:0]  CH_LAST_PIN      = 4'h7;
  localparam logic [3:0]  CH_TEMPERATURE   = 4'h8;
  localparam logic [3:0]  CH_BANDGAP       = 4'he;
  localparam logic [3:0]  CH_GROUND        = 4'hf;

  typedef enum logic {
    REF_INTERNAL_1V1 = 1'b0,
    REF_ANALOG_SUPPLY = 1'b1
  } acr_ref_t;

  typedef struct packed {
    acr_ref_t   reference;
    logic [3:0] channel;
  } acr_sel_t;

  typedef struct packed {
    logic       start;
    logic       lastCycle;
    logic       done;
    logic [9:0] result;
  } acr_conv_t;
endpackage

// ===== design/acr_select.sv
// channel/reference select, result presentation and complete flag
// assumes converter pulses start, last cycle and done on the apb clock
// assumes each converter pulse lasts exactly one clock
`timescale 1ns/100ps
module acr_select (
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic                   pslverr,
  output logic      [31:0]       prdata,
  input  wire acr_pkg::acr_conv_t conv,
  output acr_pkg::acr_sel_t      activeSel,
  output logic                   tempSensorOn,
  output logic      [7:0]        pinChannelOneHot,
  output logic                   bandgapSelect,
  output logic                   groundSelect,
  output logic                   conversionBusy
);
  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  wire        setup      = psel & ~penable;
  wire        access     = psel & penable;
  wire        hitLow     = paddr == acr_pkg::ADDR_RESULT_LOW;
  wire        hitHigh    = paddr == acr_pkg::ADDR_RESULT_HIGH;
  wire        hitSel     = paddr == acr_pkg::ADDR_CHAN_REF_SEL;
  wire        hitStatus  = paddr == acr_pkg::ADDR_CONV_STATUS;
  wire        mapped     = hitLow | hitHigh | hitSel | hitStatus;
  // byte lane 0 carries every register, other lanes are ignored
  wire        wrEnable   = access & pwrite & mapped & pstrb[0];
  wire        wrSel      = wrEnable & hitSel;
  wire        wrStatus   = wrEnable & hitStatus;

  // no wait states: every access completes in its first cycle
  assign pready  = access;
  assign pslverr = access & ~mapped;

  // ----------------------------------------------------------------------
  // software-visible select register
  // ----------------------------------------------------------------------
  logic [7:0] selReg_q;
  logic [7:0] selReg_d;
  // only writable bits are stored, so reserved ones stay zero
  assign selReg_d = wrSel ? (pwdata[7:0] & acr_pkg::SEL_WRITE_MASK)
                          : selReg_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      selReg_q <= acr_pkg::SEL_RESET;
    end else begin
      selReg_q <= selReg_d;
    end
  end

  wire        leftAdjust = selReg_q[acr_pkg::POS_LEFT_ADJUST];
  wire acr_pkg::acr_sel_t bufferSel = '{
    reference: acr_pkg::acr_ref_t'(selReg_q[acr_pkg::POS_REF_SELECT]),
    channel:   selReg_q[3:0]
  };

  // ----------------------------------------------------------------------
  // lock window and active selection
  // ----------------------------------------------------------------------
  // locked from start until the last converter cycle; done also releases
  // so a converter that skips the last-cycle pulse never sticks the lock
  logic locked_q;
  logic locked_d;
  logic busy_q;
  logic busy_d;
  assign locked_d = conv.start ? 1'b1
                  : (conv.lastCycle | conv.done) ? 1'b0 : locked_q;
  // busy spans the whole conversion, the lock ends one cycle earlier
  assign busy_d   = conv.start ? 1'b1 : conv.done ? 1'b0 : busy_q;

  acr_pkg::acr_sel_t active_q;
  acr_pkg::acr_sel_t active_d;
  // continuous copy while unlocked; start edge copies too, then holds
  assign active_d = locked_q ? active_q : bufferSel;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      locked_q <= 1'b0;
    end else begin
      locked_q <= locked_d;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
    end
  end

  // reset selection mirrors the reset value of the select register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      active_q.reference <= acr_pkg::acr_ref_t'(
          acr_pkg::SEL_RESET[acr_pkg::POS_REF_SELECT]);
      active_q.channel   <= acr_pkg::SEL_RESET[3:0];
    end else begin
      active_q <= active_d;
    end
  end

  assign activeSel      = active_q;
  assign conversionBusy = busy_q;

  // ----------------------------------------------------------------------
  // channel decode
  // ----------------------------------------------------------------------
  wire        chanIsPin  = active_q.channel <= acr_pkg::CH_LAST_PIN;
  wire        chanIsTemp = active_q.channel == acr_pkg::CH_TEMPERATURE;
  wire        chanIsBg   = active_q.channel == acr_pkg::CH_BANDGAP;
  wire        chanIsGnd  = active_q.channel == acr_pkg::CH_GROUND;
  // codes 9 to 13 are reserved and connect the ground input
  wire        chanIsRsvd = ~(chanIsPin | chanIsTemp | chanIsBg | chanIsGnd);
  wire  [7:0] pinLines;

  // one select line per analog input pin
  for (genvar p = 0; p < 8; p = p + 1) begin : g_pin
    assign pinLines[p] = chanIsPin
                       & (active_q.channel[2:0] == 3'(p));
  end
  assign pinChannelOneHot = pinLines;
  // sensor follows the active channel, so it only switches at safe points
  assign tempSensorOn     = chanIsTemp;
  assign bandgapSelect    = chanIsBg;
  // reserved codes drive groundSelect and read back as ground
  assign groundSelect     = chanIsGnd | chanIsRsvd;

  // ----------------------------------------------------------------------
  // result capture and complete flag
  // ----------------------------------------------------------------------
  logic [9:0] result_q;
  logic [9:0] result_d;
  logic       flag_q;
  logic       flag_d;
  // codes pass through unscaled; scaling is the converter's job
  wire  [9:0] doneCode = (chanIsGnd | chanIsRsvd) ? acr_pkg::CODE_GROUND
                                                  : conv.result;
  assign result_d = conv.done ? doneCode : result_q;
  // a completion in the same cycle as the clear keeps the flag set
  wire   flagClear = wrStatus & pwdata[acr_pkg::POS_FLAG];
  assign flag_d    = conv.done | (flag_q & ~flagClear);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      result_q <= acr_pkg::RESULT_RESET;
    end else begin
      result_q <= result_d;
    end
  end

  // ----------------------------------------------------------------------
  // complete flag and status
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  logic [7:0] statusView;
  always_comb begin
    statusView                    = 8'h00;
    statusView[acr_pkg::POS_FLAG] = flag_q;
    statusView[acr_pkg::POS_BUSY] = busy_q;
  end

  // ----------------------------------------------------------------------
  // result view and read data
  // ----------------------------------------------------------------------
  // view follows the live left-adjust bit, no recapture needed
  wire  [7:0] viewHigh = leftAdjust ? result_q[9:2]
                                    : {6'h00, result_q[9:8]};
  wire  [7:0] viewLow  = leftAdjust ? {result_q[1:0], 6'h00}
                                    : result_q[7:0];
  wire  [7:0] readByte =
      hitLow    ? viewLow  :
      hitHigh   ? viewHigh :
      hitSel    ? selReg_q :
      hitStatus ? statusView : 8'h00;

  // upper bytes always read zero: every register is one byte wide
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  // read data sampled in setup so it stands through the one access cycle
  assign prdata_d = (setup & ~pwrite) ? {24'h000000, readByte} : prdata_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prdata_q <= 32'h00000000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  assign prdata = prdata_q;
endmodule

// ===== bench/acr_select_sva.sv
// assertions on the ports of the select block
// assumes binding into every acr_select instance
`timescale 1ns/100ps
module acr_select_sva (
  input wire logic               clock,
  input wire logic               rst_b,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [3:0]         pstrb,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic [31:0]        prdata,
  input wire acr_pkg::acr_conv_t conv,
  input wire acr_pkg::acr_sel_t  activeSel,
  input wire logic               tempSensorOn,
  input wire logic [7:0]         pinChannelOneHot,
  input wire logic               bandgapSelect,
  input wire logic               groundSelect,
  input wire logic               conversionBusy
);
  wire logic [3:0] ch = activeSel.channel;
  wire logic       acc = psel && penable;
  wire logic       selHit = acc && paddr == 12'h1f0;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  AST_TEMP: assert property (tempSensorOn == (ch == 4'h8))
    else $error("temperature decode wrong");
  AST_DECODE: assert property (bandgapSelect == (ch == 4'he)
    && groundSelect == (ch == 4'hf || (ch > 4'h8 && ch < 4'he)))
    else $error("bandgap or ground decode wrong");
  AST_PINS: assert property (pinChannelOneHot ==
    (ch < 4'h8 ? 8'h01 << ch[2:0] : 8'h00)) else $error("pin decode wrong");
  AST_RSVD: assert property (selHit && !pwrite |->
    prdata[31:7] == 25'h0 && !prdata[4]) else $error("reserved bits read");
  AST_FOLLOW: assert property (selHit && pwrite && pstrb[0]
    && !conversionBusy && !conv.start |-> ##2 activeSel ==
    {$past(pwdata[6], 2), $past(pwdata[3:0], 2)}) else $error("no follow");
  AST_LOCK: assert property (conv.start ##1
    !(conv.lastCycle || conv.done) |=> $stable(activeSel))
    else $error("selection moved while locked");
  AST_BUSY: assert property (conv.start || conv.done |=>
    conversionBusy == $past(conv.start)) else $error("busy wrong");
  AST_ERR: assert property (acc && paddr[11:4] < 8'h1e |-> pslverr)
    else $error("unmapped address accepted");
endmodule
bind acr_select acr_select_sva chk (.*);

// ===== bench/acr_conv_model.sv
// converter stand-in: start, last cycle and done pulses with a code
// assumes go is a one-cycle request on the same clock
`timescale 1ns/100ps
module acr_conv_model #(
  parameter int LEN = 12
) (
  input  wire logic         clock,
  input  wire logic         rst_b,
  input  wire logic         go,
  input  wire logic [9:0]   code,
  output acr_pkg::acr_conv_t conv
);
  int cnt;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 0;
      conv <= '0;
    end else begin
      cnt <= go ? LEN : (cnt > 0 ? cnt - 1 : 0);
      conv.start <= go;
      conv.lastCycle <= cnt == 2;
      conv.done <= cnt == 1;
      // only trusted with done, so scrambled otherwise
      conv.result <= cnt == 1 ? code : ~code;
    end
  end
endmodule

// ===== bench/adc_channel_reference_select_test.sv
// self-checking bench: apb master, converter model, reference model
// assumes package, design, checker and model compiled before
`timescale 1ns/100ps
module adc_channel_reference_select_test;
  logic clock = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, go = 1'b0, err, pready, pslverr;
  logic tempSensorOn, bandgapSelect, groundSelect, conversionBusy;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic [3:0] pstrb = 4'h1;
  logic [9:0] code = 10'h000;
  logic [7:0] pinChannelOneHot;
  acr_pkg::acr_conv_t conv;
  acr_pkg::acr_sel_t activeSel;
  int failures = 0, testsRun = 0, sel, res;
  // results of finished conversions, newest last
  int hist[$];
  logic [10:0] dec, want;
  // settling scaled down: the converter stand-in is ideal and a real
  // settling time would not fit the run budget
  localparam int SETTLE = 16;
  always #2.5 clock = ~clock;
  acr_select dut (.*);
  acr_conv_model model (.*);
  task automatic chk(input logic [31:0] got, exp);
    testsRun++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input int d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  function automatic logic [31:0] view(input int r, input logic a, h);
    logic [15:0] v;
    v = a ? {r[9:0], 6'h00} : {6'h00, r[9:0]};
    return h ? v[15:8] : v[7:0];
  endfunction
  task automatic reportAndStop;
    $display("checks %0d failures %0d", testsRun, failures);
    if (failures == 0 && testsRun > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hd75d));
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 4; i++) begin
      apb(0, 12'h1e0 + 12'(i[1] * 16 + i[0] * 4), 0);
      chk(rd, 32'h0);
    end
    apb(0, 12'h000, 0);
    chk({err, rd[30:0]}, 32'h80000000);
    // a write with byte lane 0 off must leave the select register alone
    pstrb <= 4'h0;
    apb(1, 12'h1f0, 32'h6f);
    pstrb <= 4'h1;
    apb(0, 12'h1f0, 0);
    chk(rd, 32'h0);
    $display("test reset done");
    // every channel code once, reference and reserved bits random
    for (int n = 0; n < 16; n++) begin
      sel = ($urandom & 32'hf0) | n;
      // temperature needs the internal reference
      if (n == 8) sel = sel & ~32'h40;
      apb(1, 12'h1f0, sel);
      apb(0, 12'h1f0, 0);
      chk(rd, sel & 32'h6f);
      chk(32'(activeSel), (sel >> 2 & 16) | n);
      dec = {tempSensorOn, bandgapSelect, groundSelect, pinChannelOneHot};
      want = {n == 8, n == 14, n > 8 && n != 14, 8'(n < 8 ? 1 << n : 0)};
      chk(32'(dec), 32'(want));
      if (!sel[6]) repeat (SETTLE) @(posedge clock);
      // converter input only changes while no conversion runs
      code <= 10'($urandom);
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      sel = sel ^ 32'h6f;
      apb(1, 12'h1f0, sel);
      apb(0, 12'h1e4, 0);
      chk(rd, view(hist.size() ? hist[$] : 0, sel[5], 1'b1));
      chk(32'(activeSel), ((sel ^ 32'h40) >> 2 & 16) | n);
      // bus left quiet until completion, as with the core asleep
      do @(posedge clock); while (conv.done !== 1'b1);
      res = (n > 8 && n != 14) ? 0 : code;
      apb(0, 12'h1f4, 0);
      chk(rd, 32'h1);
      for (int h = 0; h < 2; h++) begin
        apb(0, 12'h1e0 + 12'(h * 4), 0);
        chk(rd, view(res, sel[5], h[0]));
      end
      chk(32'(activeSel), (sel >> 2 & 16) | (sel & 15));
      apb(1, 12'h1f4, 1);
      apb(0, 12'h1f4, 0);
      chk(rd, 32'h0);
      hist.push_back(res);
    end
    $display("test convert done");
    reportAndStop();
  end
  initial begin
    #100000;
    failures++;
    reportAndStop();
  end
endmodule
